// ---- bench/dppc_switch_model.sv ----
// external power switches and current monitors on the seven pins
// assumes pad drive from dppc_top; wire level goes back to pad_in
`timescale 1ns/1ns
module dppc_switch_model (
  input wire logic clk_in, // core clock
  input dppc_pkg::dppc_pad_t [6:0] pads_in, // pad drive
  input wire logic [6:0] fault_in, // monitor flags overcurrent
  output logic [6:0] level_out // resolved wire levels
);
  import dppc_pkg::*;
  logic [6:0] junk_q = 7'h00;
  // floating wire shows a pattern that changes every cycle
  always @(posedge clk_in)
    junk_q <= ~junk_q;
  // pull-up powers switch, monitor pulls low
  always_comb
    for (int i = 0; i < 7; i++)
      level_out[i] = (pads_in[i].oe | fault_in[i]) ? 1'b0 :
        (pads_in[i].pu ? 1'b1 : junk_q[i]);
endmodule : dppc_switch_model

// ---- bench/dppc_top_test.sv ----
// self-checking bench for the port power control block
// assumes dppc_top and the switch model; pins resolved by the model
`timescale 1ns/1ns
module dppc_top_test;
  import dppc_pkg::*;
  logic clk_in, rst_n_in, ganged;
  logic [5:0] en, clr, flag, now;
  logic [6:0] fault, lvl;
  dppc_pad_t [6:0] pads;
  int num_errors = 0;
  int compares = 0;
  // {ganged, enables} beside expected {oe[6:0], pu[6:0]}
  logic [20:0] rows [4] = '{{7'h3F, 14'h203F}, {7'h15, 14'h3515},
    {7'h41, 14'h1FC0}, {7'h40, 14'h3F80}};
  dppc_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .ganged_in(ganged), .port_en_in(en), .oc_clear_in(clr),
    .pad_in(lvl), .pad_out(pads), .oc_flag_out(flag),
    .oc_now_out(now));
  dppc_switch_model sw (.clk_in(clk_in), .pads_in(pads),
    .fault_in(fault), .level_out(lvl));
  // pack pad drive as {oe, pu}
  function automatic logic [13:0] drv(input dppc_pad_t [6:0] p);
    for (int i = 0; i < 7; i++)
    begin
      drv[i + 7] = p[i].oe;
      drv[i] = p[i].pu;
    end
  endfunction : drv
  // pack the driven level of each pad
  function automatic logic [6:0] lows(input dppc_pad_t [6:0] p);
    for (int i = 0; i < 7; i++)
      lows[i] = p[i].out;
  endfunction : lows
  task automatic chk_pad(input logic [13:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected pads at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk_pad
  task automatic chk_oc(input logic [5:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected flags at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk_oc
  task automatic finish_test();
    if (num_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // clock generator, 8 ns period
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // watchdog well past the expected run length
  initial
  begin
    #20000;
    num_errors++;
    finish_test();
  end
  // main sequence, inputs changed on falling edges
  initial
  begin
    rst_n_in = 1'b0;
    {ganged, en, clr, fault} = '0;
    repeat (10) @(negedge clk_in);
    chk_pad(drv(pads), 14'h3F80);
    rst_n_in = 1'b1;
    foreach (rows[r])
    begin
      {ganged, en} = rows[r][20:14];
      repeat (4) @(negedge clk_in);
      chk_pad(drv(pads), rows[r][13:0]);
      chk_pad({7'h00, lows(pads)}, 14'h0000);
    end
    {ganged, en} = 7'h3E;
    repeat (50) @(negedge clk_in);
    fault = 7'h04;
    repeat (8) @(negedge clk_in);
    chk_oc(flag, 6'h00);
    chk_oc(now, 6'h00);
    fault = 7'h00;
    repeat (90) @(negedge clk_in);
    fault = 7'h04;
    repeat (4) @(negedge clk_in);
    chk_oc(flag, 6'h04);
    chk_oc(now, 6'h04);
    fault = 7'h00;
    repeat (4) @(negedge clk_in);
    chk_oc(now, 6'h00);
    chk_oc(flag, 6'h04);
    clr = 6'h04;
    @(negedge clk_in);
    clr = 6'h00;
    repeat (2) @(negedge clk_in);
    chk_oc(flag, 6'h00);
    {ganged, en} = 7'h7F;
    repeat (140) @(negedge clk_in);
    fault = 7'h40;
    repeat (4) @(negedge clk_in);
    chk_oc(flag, 6'h3F);
    chk_oc(now, 6'h3F);
    clr = 6'h01;
    repeat (2) @(negedge clk_in);
    chk_oc(flag, 6'h3F);
    clr = 6'h00;
    rst_n_in = 1'b0;
    @(negedge clk_in);
    chk_pad(drv(pads), 14'h3F80);
    chk_oc(flag, 6'h00);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    chk_pad(drv(pads), 14'h1FC0);
    chk_oc(flag, 6'h00);
    chk_oc(now, 6'h00);
    finish_test();
  end
endmodule : dppc_top_test

// ---- rtl/dppc_defines.svh ----
// constants for the downstream port power control block
// assumes a single 125 MHz core clock and open-drain pads with pull-ups
//
// Functional notes
// R01: enabled port releases its pin as input with pull-up applied
// R02: pulled-up pin level is the power-on request to the external switch
// R03: external monitor pulls pin low on overcurrent; watched while enabled
// R04: disabled port pin becomes output driven low, removing port power
// R05: six identical independent per-port pins, ports 1 to 6
// R06: ganged mode uses the shared pin as control for all ports
// R07: in ganged mode external controllers hang off the shared pin only
// R08: pins synchronised; low while enabled latches sticky overcurrent flag
`ifndef DPPC_DEFINES_SVH
`define DPPC_DEFINES_SVH

`define DPPC_NUM_PORTS 6
`define DPPC_NUM_CH 7
`define DPPC_GANG_CH 6
`define DPPC_CNT_W 7
`define DPPC_CLK_PERIOD_NS 8
`define DPPC_SETTLE_NS 1000
`define DPPC_SETTLE_CYC \
  ((`DPPC_SETTLE_NS + `DPPC_CLK_PERIOD_NS - 1) / `DPPC_CLK_PERIOD_NS)
`define DPPC_RST_OE 1'b1
`define DPPC_RST_PU 1'b0
`define DPPC_RST_FLAG 1'b0

`endif

// ---- rtl/dppc_pkg.sv ----
// types for the downstream port power control block
// assumes dppc_defines.svh is on the include path
`include "dppc_defines.svh"

package dppc_pkg;

  // drive controls of one open-drain pad
  typedef struct packed {
    logic out;
    logic oe;
    logic pu;
  } dppc_pad_t;

  // power switching mode
  typedef enum logic {
    DPPC_INDIVIDUAL,
    DPPC_GANGED
  } dppc_mode_t;

endpackage : dppc_pkg

// ---- rtl/dppc_top.sv ----
// downstream port power enable and overcurrent sense for six ports
// assumes enables come from hub config logic on clk_in and pads resolve
// the wire level from oe and pu outside this module
`timescale 1ns/1ns
`include "dppc_defines.svh"

module dppc_top (
  input wire logic clk_in, // 125 MHz core clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic ganged_in, // 1 selects ganged power mode
  input wire logic [`DPPC_NUM_PORTS-1:0] port_en_in, // port enabled
  input wire logic [`DPPC_NUM_PORTS-1:0] oc_clear_in, // clear flag pulse
  input wire logic [`DPPC_NUM_CH-1:0] pad_in, // pin levels, [6] shared
  output dppc_pkg::dppc_pad_t [`DPPC_NUM_CH-1:0] pad_out, // pad drive
  output logic [`DPPC_NUM_PORTS-1:0] oc_flag_out, // sticky overcurrent
  output logic [`DPPC_NUM_PORTS-1:0] oc_now_out // overcurrent level
);
  import dppc_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_n_q;
  dppc_mode_t mode_q;
  logic [`DPPC_NUM_CH-1:0] ch_en;
  logic [`DPPC_NUM_CH-1:0] oe_q;
  logic [`DPPC_NUM_CH-1:0] pu_q;
  logic [`DPPC_NUM_CH-1:0] meta_q;
  logic [`DPPC_NUM_CH-1:0] pin_q;
  logic [`DPPC_NUM_CH-1:0] sense_ok;
  logic [`DPPC_NUM_CH-1:0] oc_raw;
  logic [`DPPC_NUM_PORTS-1:0] oc_set;
  logic [`DPPC_NUM_PORTS-1:0] oc_q;
  logic [`DPPC_NUM_PORTS-1:0] oc_now_q;

  // assertions sample on the core clock and stay quiet in reset
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_q);

  // mode decode shared by the enables and the checks
  function automatic logic gang_sel(input dppc_mode_t mode);
    return mode == DPPC_GANGED;
  endfunction : gang_sel

  // reset release through two flip-flops
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n_q = rst_sync_q[1];

  // mode register
  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
      mode_q <= DPPC_INDIVIDUAL;
    else
      mode_q <= ganged_in ? DPPC_GANGED : DPPC_INDIVIDUAL;
  end

  // channel enables: per-port pins in individual mode, shared pin when ganged
  // R06 shared pin control
  always_comb
  begin
    for (int i = 0; i < `DPPC_NUM_PORTS; i++)
      ch_en[i] = port_en_in[i] && !gang_sel(mode_q);
    ch_en[`DPPC_GANG_CH] = (|port_en_in) && gang_sel(mode_q);
  end

  // one identical channel per pin
  // R05 identical channels
  genvar g;
  generate
    for (g = 0; g < `DPPC_NUM_CH; g++)
    begin : g_ch
      logic [`DPPC_CNT_W-1:0] cnt_q;

      // R01 release when enabled
      // R04 drive low when disabled
      always_ff @(posedge clk_in or negedge rst_n_q)
      begin
        if (!rst_n_q)
        begin
          oe_q[g] <= `DPPC_RST_OE;
          pu_q[g] <= `DPPC_RST_PU;
        end
        else
        begin
          oe_q[g] <= !ch_en[g];
          pu_q[g] <= ch_en[g];
        end
      end

      // R02 pull-up requests power
      assign pad_out[g].pu = pu_q[g];
      assign pad_out[g].oe = oe_q[g];
      assign pad_out[g].out = 1'b0; // only ever drives low

      // R08 two-flop pin synchroniser
      // flops start high so the idle pull-up level reads as no fault
      always_ff @(posedge clk_in or negedge rst_n_q)
      begin
        if (!rst_n_q)
        begin
          meta_q[g] <= 1'b1;
          pin_q[g] <= 1'b1;
        end
        else
        begin
          meta_q[g] <= pad_in[g];
          pin_q[g] <= meta_q[g];
        end
      end

      // settle blanking so our own low drive is not read as overcurrent
      always_ff @(posedge clk_in or negedge rst_n_q)
      begin
        if (!rst_n_q)
          cnt_q <= '0;
        else if (!pu_q[g])
          cnt_q <= '0;
        else if (cnt_q != `DPPC_CNT_W'(`DPPC_SETTLE_CYC))
          cnt_q <= cnt_q + `DPPC_CNT_W'(1);
      end

      // R03 active-low sense
      assign sense_ok[g] = pu_q[g] &&
                           (cnt_q == `DPPC_CNT_W'(`DPPC_SETTLE_CYC));
      assign oc_raw[g] = sense_ok[g] && !pin_q[g];

      // R03 sense only while enabled
      a_sense_when_en: assert property // R03
        (oc_raw[g] |-> pu_q[g] && !oe_q[g])
        else $error("overcurrent sensed on disabled pin");
      // R03 blank after release
      a_settle_blank: assert property // R03
        ($rose(pu_q[g]) |-> (!sense_ok[g]) [*8])
        else $error("sense enabled before settle time");
      // R01 enable releases pin
      // the edge that ends reset still loads the reset values
      a_en_release: assert property // R01
        (rst_n_q && ch_en[g] |=> !oe_q[g] && pu_q[g])
        else $error("enabled pin not released");
      // R04 disable drives low
      a_dis_drive: assert property // R04
        (!ch_en[g] |=> oe_q[g] && !pu_q[g])
        else $error("disabled pin not driven low");
    end
  endgenerate

  // overcurrent events per port, shared pin fans out to all when ganged
  // R06 shared pin sense
  always_comb
  begin
    for (int i = 0; i < `DPPC_NUM_PORTS; i++)
      oc_set[i] = oc_raw[i] || oc_raw[`DPPC_GANG_CH];
  end

  // R08 sticky flags, set wins over clear
  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
      oc_q <= {`DPPC_NUM_PORTS{`DPPC_RST_FLAG}};
    else
      oc_q <= oc_set | (oc_q & ~oc_clear_in);
  end

  // live overcurrent level
  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
      oc_now_q <= '0;
    else
      oc_now_q <= oc_set;
  end

  // outputs come straight from their flops
  assign oc_flag_out = oc_q;
  assign oc_now_out = oc_now_q;

  // R08 event latches flag
  a_oc_latch: assert property // R08
    (|oc_set |=> (oc_q & $past(oc_set)) == $past(oc_set))
    else $error("overcurrent event not latched");
  // R08 set beats clear
  a_set_wins: assert property // R08
    (oc_set[0] && oc_clear_in[0] |=> oc_q[0])
    else $error("clear beat simultaneous set");
  // R08 flag holds until cleared
  a_flag_hold: assert property // R08
    (oc_q[1] && !oc_clear_in[1] |=> oc_q[1])
    else $error("flag dropped without clear");
  // R08 clear removes flag
  a_flag_clear: assert property // R08
    (oc_q[2] && oc_clear_in[2] && !oc_set[2] |=> !oc_q[2])
    else $error("flag not cleared");
  // R06 ganged holds port pins low
  a_gang_ports: assert property // R06
    (gang_sel(mode_q) |=> &oe_q[`DPPC_NUM_PORTS-1:0])
    else $error("port pin released in ganged mode");
  // R06 ganged powers shared pin
  a_gang_shared: assert property // R06
    (gang_sel(mode_q) && |port_en_in |=> pu_q[`DPPC_GANG_CH])
    else $error("shared pin not released in ganged mode");
  // R06 shared pin low
  a_gang_quiet: assert property // R06
    (!gang_sel(mode_q) |=> oe_q[`DPPC_GANG_CH] && !pu_q[`DPPC_GANG_CH])
    else $error("shared pin released in individual mode");
  // R06 shared pin flags all ports
  a_gang_fanout: assert property // R06
    (oc_raw[`DPPC_GANG_CH] |=> &oc_q)
    else $error("shared overcurrent not on every port");

  // main scenarios: port and shared faults, clear, set wins, disable
  c_port_oc: cover property (pu_q[0] ##1 oc_raw[0] ##1 oc_q[0]);
  c_gang_oc: cover property (mode_q == DPPC_GANGED ##1 oc_raw[`DPPC_GANG_CH]);
  c_clear: cover property (oc_q[3] ##1 oc_clear_in[3] ##1 !oc_q[3]);
  c_set_wins: cover property (oc_set[0] && oc_clear_in[0] ##1 oc_q[0]);
  c_disable: cover property (pu_q[4] ##1 !pu_q[4]);

endmodule : dppc_top
